// ### hw/pin_routing_pkg.sv
package pin_routing_pkg;

    localparam int unsigned SEL_W       = 6;
    localparam int unsigned NUM_PINS    = 24;
    localparam int unsigned NUM_INPUTS  = 30;
    localparam int unsigned NUM_SOURCES = 36;
    localparam int unsigned ADDR_W      = 7;
    localparam int unsigned DATA_W      = 32;

    // Input selector fields: port in bits 5:3, pin number in bits 2:0.
    localparam int unsigned PORT_LSB   = 3;
    localparam int unsigned PORT_MSB   = 5;
    localparam int unsigned PIN_IDX_W  = 5;
    localparam logic [2:0]  PORT_A     = 3'h0;
    localparam logic [2:0]  PORT_B     = 3'h1;
    localparam logic [2:0]  PORT_C     = 3'h2;

    // Register word addresses.
    localparam logic [ADDR_W-1:0] IN_SEL_BASE  = 7'h00;
    localparam logic [ADDR_W-1:0] OUT_SEL_BASE = 7'h20;
    localparam logic [ADDR_W-1:0] PIN_LEVEL    = 7'h38;

    // Output source codes.
    localparam logic [SEL_W-1:0] SRC_LATCH     = 6'h00;
    localparam logic [SEL_W-1:0] SRC_LOGIC1    = 6'h01;
    localparam logic [SEL_W-1:0] SRC_CWG_A     = 6'h05;
    localparam logic [SEL_W-1:0] SRC_CAPTURE_COMPARE_UNIT      = 6'h09;
    localparam logic [SEL_W-1:0] SRC_PWM1_P1   = 6'h0B;
    localparam logic [SEL_W-1:0] SRC_RSV_LO    = 6'h0F;
    localparam logic [SEL_W-1:0] SRC_RSV_HI    = 6'h12;
    localparam logic [SEL_W-1:0] SRC_TXCK1     = 6'h13;
    localparam logic [SEL_W-1:0] SRC_RSV_A     = 6'h14;
    localparam logic [SEL_W-1:0] SRC_DT1       = 6'h15;
    localparam logic [SEL_W-1:0] SRC_TXCK2     = 6'h16;
    localparam logic [SEL_W-1:0] SRC_RSV_B     = 6'h17;
    localparam logic [SEL_W-1:0] SRC_DT2       = 6'h18;
    localparam logic [SEL_W-1:0] SRC_CMP1      = 6'h19;
    localparam logic [SEL_W-1:0] SRC_SSP1_CLK  = 6'h1B;
    localparam logic [SEL_W-1:0] SRC_TIMER0    = 6'h1F;
    localparam logic [SEL_W-1:0] SRC_NUM_OSC   = 6'h20;
    localparam logic [SEL_W-1:0] SRC_REF_CLK   = 6'h21;
    localparam logic [SEL_W-1:0] SRC_GUARD_B   = 6'h23;
    localparam logic [SEL_W-1:0] OUT_SEL_RESET = 6'h00;

    // Input selector power-on defaults, index 29 first, index 0 last.
    localparam logic [NUM_INPUTS-1:0][SEL_W-1:0] IN_DEFAULT_20 = '{
        6'h12, 6'h10, 6'h11, 6'h0F, 6'h0D, 6'h01, 6'h0D, 6'h0F, 6'h16, 6'h0C,
        6'h0E, 6'h0D, 6'h0C, 6'h13, 6'h02, 6'h02, 6'h11, 6'h05, 6'h13, 6'h15,
        6'h13, 6'h15, 6'h11, 6'h05, 6'h14, 6'h15, 6'h04, 6'h05, 6'h02, 6'h02};
    localparam logic [NUM_INPUTS-1:0][SEL_W-1:0] IN_DEFAULT_14 = '{
        6'h12, 6'h10, 6'h11, 6'h14, 6'h15, 6'h00, 6'h15, 6'h14, 6'h13, 6'h11,
        6'h10, 6'h05, 6'h11, 6'h14, 6'h13, 6'h02, 6'h11, 6'h05, 6'h13, 6'h15,
        6'h13, 6'h15, 6'h11, 6'h05, 6'h14, 6'h15, 6'h04, 6'h05, 6'h02, 6'h02};

    // True when the selector names a port that exists.
    function automatic logic sel_valid(input logic [SEL_W-1:0] sel);
        sel_valid = (sel[PORT_MSB:PORT_LSB] <= PORT_C);
    endfunction

    // Flat pin index: port times eight plus pin number.
    function automatic logic [PIN_IDX_W-1:0] sel_pin(input logic [SEL_W-1:0] sel);
        sel_pin = sel[PIN_IDX_W-1:0];
    endfunction

endpackage

// ### hw/input_route_mux.sv
`timescale 1ns/1ps
module input_route_mux (
    input  wire logic [pin_routing_pkg::SEL_W-1:0]    sel,
    input  wire logic [pin_routing_pkg::NUM_PINS-1:0] pin_level,
    output logic                                      routed
);

    // A selector naming a missing port feeds a constant low.
    always_comb begin
        if (pin_routing_pkg::sel_valid(sel)) begin
            routed = pin_level[pin_routing_pkg::sel_pin(sel)];
        end else begin
            routed = 1'b0;
        end
    end

endmodule

// ### hw/peripheral_pin_router.sv
// Contract
// - Only digital peripheral signals pass through the selection logic.
// - Analog signals stay on fixed pins; no selector can move them.
// - Input and output selectors are separate and never affect each other.
// - Each digital peripheral input has its own selector naming its pin.
// - Small packages let every input selector reach any I/O pin.
// - Several inputs may select one pin and all see its level.
// - Port reads always return the true pin level.
// - Routed digital input is enabled only while the pin's analog bit is clear.
// - Each port pin has its own output source selector.
// - Direction control bit still enables or disables the pin driver.
// - Driver-managing peripherals override the direction bit when they need to.
// - Code 00 drives the latch; 01 to 04 select logic cells 1-4.
// - Codes 05-08 waveform A-D, 09-0A capture units, 0B-0E PWM slices.
// - Codes 13 to 23 except 14 and 17 select serial, comparator, timer, clock, guard sources; rest reserved.
// - Power-on loads each input selector with its package default pin code.
// - Input selector holds port in bits 5:3 and pin in bits 2:0.
// - Power-on restores input defaults and clears output selectors; nothing else does.
`timescale 1ns/1ps
module peripheral_pin_router #(
    parameter bit PKG_20_PIN = 1'b1
) (
    input  wire logic                                         clk_sys,
    input  wire logic                                         rst,
    input  wire logic [pin_routing_pkg::ADDR_W-1:0]           avs_address,
    input  wire logic                                         avs_read,
    input  wire logic                                         avs_write,
    input  wire logic [pin_routing_pkg::DATA_W-1:0]           avs_writedata,
    input  wire logic [3:0]                                   avs_byteenable,
    output logic [pin_routing_pkg::DATA_W-1:0]                avs_readdata,
    output logic                                              avs_waitrequest,
    input  wire logic [pin_routing_pkg::NUM_PINS-1:0]         pad_in,
    output logic [pin_routing_pkg::NUM_PINS-1:0]              pad_out,
    output logic [pin_routing_pkg::NUM_PINS-1:0]              pad_oe_n,
    input  wire logic [pin_routing_pkg::NUM_PINS-1:0]         analog_select_bit,
    input  wire logic [pin_routing_pkg::NUM_PINS-1:0]         pin_direction_control,
    input  wire logic [pin_routing_pkg::NUM_PINS-1:0]         port_latch_bit,
    input  wire logic [pin_routing_pkg::NUM_SOURCES-1:1]      periph_out,
    input  wire logic [pin_routing_pkg::NUM_SOURCES-1:1]      periph_dir_override,
    input  wire logic [pin_routing_pkg::NUM_SOURCES-1:1]      periph_drive_n,
    output logic [pin_routing_pkg::NUM_INPUTS-1:0]            periph_in,
    output logic [pin_routing_pkg::NUM_PINS-1:0]              port_level
);

    typedef struct packed {
        logic [pin_routing_pkg::NUM_INPUTS-1:0][pin_routing_pkg::SEL_W-1:0] in_sel;
        logic [pin_routing_pkg::NUM_PINS-1:0][pin_routing_pkg::SEL_W-1:0]   out_sel;
        logic                                                              waitreq;
        logic [pin_routing_pkg::DATA_W-1:0]                                readdata;
        logic [pin_routing_pkg::NUM_PINS-1:0]                              pad_out;
        logic [pin_routing_pkg::NUM_PINS-1:0]                              pad_oe_n;
        logic [pin_routing_pkg::NUM_INPUTS-1:0]                            periph_in;
        logic [pin_routing_pkg::NUM_PINS-1:0]                              port_level;
    } state_s;

    localparam logic [pin_routing_pkg::NUM_INPUTS-1:0][pin_routing_pkg::SEL_W-1:0] IN_RESET =
        PKG_20_PIN ? pin_routing_pkg::IN_DEFAULT_20 : pin_routing_pkg::IN_DEFAULT_14;

    state_s                                   st;
    state_s                                   next_st;
    logic [pin_routing_pkg::NUM_PINS-1:0]     digital_level;
    logic [pin_routing_pkg::NUM_INPUTS-1:0]   routed;
    logic                                     bus_req;
    logic                                     bus_accept;
    logic                                     hit_in;
    logic                                     hit_out;
    logic [pin_routing_pkg::ADDR_W-1:0]       out_offset;

    // Reserved codes and codes past the table drive low and leave the direction bit in charge.
    function automatic logic code_reserved(input logic [pin_routing_pkg::SEL_W-1:0] code);
        code_reserved = ((code >= pin_routing_pkg::SRC_RSV_LO) &&
                         (code <= pin_routing_pkg::SRC_RSV_HI)) ||
                        (code == pin_routing_pkg::SRC_RSV_A) ||
                        (code == pin_routing_pkg::SRC_RSV_B) ||
                        (code > pin_routing_pkg::SRC_GUARD_B);
    endfunction

    function automatic logic code_is_peripheral(input logic [pin_routing_pkg::SEL_W-1:0] code);
        code_is_peripheral = (code != pin_routing_pkg::SRC_LATCH) && !code_reserved(code);
    endfunction

    assign bus_req    = avs_read || avs_write;
    assign bus_accept = bus_req && !st.waitreq;
    assign out_offset = avs_address - pin_routing_pkg::OUT_SEL_BASE;
    assign hit_in     = (avs_address < pin_routing_pkg::IN_SEL_BASE +
                         7'(pin_routing_pkg::NUM_INPUTS));
    assign hit_out    = (avs_address >= pin_routing_pkg::OUT_SEL_BASE) &&
                        (out_offset < 7'(pin_routing_pkg::NUM_PINS));

    // Analog signals never enter here; the gate below only blocks the digital buffer.
    assign digital_level = pad_in & ~analog_select_bit;

    // One mux per peripheral input; several may name the same pin at once.
    genvar gi;
    generate
        for (gi = 0; gi < pin_routing_pkg::NUM_INPUTS; gi++) begin : g_in_route
            input_route_mux u_mux (
                .sel       (st.in_sel[gi]),
                .pin_level (digital_level),
                .routed    (routed[gi])
            );
        end
    endgenerate

    always_comb begin
        logic [pin_routing_pkg::SEL_W-1:0] code;
        code    = '0;
        next_st = st;

        // Waitrequest drops for exactly one cycle per request.
        if (bus_req && st.waitreq) begin
            next_st.waitreq  = 1'b0;
            next_st.readdata = '0;
            if (hit_in) begin
                next_st.readdata[pin_routing_pkg::SEL_W-1:0] = st.in_sel[avs_address[4:0]];
            end else if (hit_out) begin
                next_st.readdata[pin_routing_pkg::SEL_W-1:0] = st.out_sel[out_offset[4:0]];
            end else if (avs_address == pin_routing_pkg::PIN_LEVEL) begin
                next_st.readdata[pin_routing_pkg::NUM_PINS-1:0] = st.port_level;
            end
        end else begin
            next_st.waitreq = 1'b1;
        end

        // Input and output selectors sit at separate addresses and are written apart.
        if (bus_accept && avs_write && avs_byteenable[0]) begin
            if (hit_in) begin
                next_st.in_sel[avs_address[4:0]] =
                    avs_writedata[pin_routing_pkg::SEL_W-1:0];
            end else if (hit_out) begin
                next_st.out_sel[out_offset[4:0]] =
                    avs_writedata[pin_routing_pkg::SEL_W-1:0];
            end
        end

        next_st.periph_in  = routed;
        next_st.port_level = pad_in;

        for (int i = 0; i < pin_routing_pkg::NUM_PINS; i++) begin
            code = st.out_sel[i];
            if (code == pin_routing_pkg::SRC_LATCH) begin
                next_st.pad_out[i] = port_latch_bit[i];
            end else if (code_is_peripheral(code)) begin
                next_st.pad_out[i] = periph_out[code];
            end else begin
                next_st.pad_out[i] = 1'b0;
            end
            if (code_is_peripheral(code) && periph_dir_override[code]) begin
                next_st.pad_oe_n[i] = periph_drive_n[code];
            end else begin
                next_st.pad_oe_n[i] = pin_direction_control[i];
            end
        end
    end

    // The reset input is the power-on/brown-out reset; lesser resets never reach this block.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st            <= '0;
            st.in_sel     <= IN_RESET;
            st.out_sel    <= '{default: pin_routing_pkg::OUT_SEL_RESET};
            st.waitreq    <= 1'b1;
            st.pad_oe_n   <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata    = st.readdata;
    assign avs_waitrequest = st.waitreq;
    assign pad_out         = st.pad_out;
    assign pad_oe_n        = st.pad_oe_n;
    assign periph_in       = st.periph_in;
    assign port_level      = st.port_level;

    AST_LATCH_SOURCE: assert property (@(posedge clk_sys) disable iff (rst)
        (st.out_sel[0] == pin_routing_pkg::SRC_LATCH) |=>
            (pad_out[0] == $past(port_latch_bit[0])))
        else $error("latch code did not drive pin 0 from its latch bit");

    // Pin 4 is the pin that the source sweep exercises, so these checks see real traffic.
    AST_DIRECTION_KEPT: assert property (@(posedge clk_sys) disable iff (rst)
        (st.out_sel[4] == pin_routing_pkg::SRC_CAPTURE_COMPARE_UNIT) && !periph_dir_override[9] |=>
            (pad_oe_n[4] == $past(pin_direction_control[4])))
        else $error("direction bit lost control of pin 4 driver");

    AST_DRIVER_OVERRIDE: assert property (@(posedge clk_sys) disable iff (rst)
        (st.out_sel[4] == pin_routing_pkg::SRC_SSP1_CLK) && periph_dir_override[27] |=>
            (pad_oe_n[4] == $past(periph_drive_n[27])))
        else $error("peripheral driver override ignored on pin 4");

    AST_PERIPH_SOURCE: assert property (@(posedge clk_sys) disable iff (rst)
        (st.out_sel[4] == pin_routing_pkg::SRC_TIMER0) |=>
            (pad_out[4] == $past(periph_out[31])))
        else $error("timer source not routed to pin 4");

    AST_RESERVED_LOW: assert property (@(posedge clk_sys) disable iff (rst)
        code_reserved(st.out_sel[4]) |=> !pad_out[4])
        else $error("reserved code drove pin 4 high");

    AST_INPUT_GATED: assert property (@(posedge clk_sys) disable iff (rst)
        pin_routing_pkg::sel_valid(st.in_sel[0]) |=>
            (periph_in[0] == $past(pad_in[pin_routing_pkg::sel_pin(st.in_sel[0])] &&
                                   !analog_select_bit[pin_routing_pkg::sel_pin(st.in_sel[0])])))
        else $error("input 0 does not follow its gated pin");

    AST_SHARED_PIN: assert property (@(posedge clk_sys) disable iff (rst)
        (st.in_sel[0] == st.in_sel[1]) |=> (periph_in[0] == periph_in[1]))
        else $error("inputs sharing a pin saw different levels");

    AST_PORT_READ: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> (port_level == $past(pad_in)))
        else $error("port level differs from pad level");

    AST_WRITE_LAG: assert property (@(posedge clk_sys) disable iff (rst)
        bus_accept && avs_write && avs_byteenable[0] &&
            (avs_address == pin_routing_pkg::OUT_SEL_BASE) |=>
            (st.out_sel[0] == $past(avs_writedata[pin_routing_pkg::SEL_W-1:0])) ##1
            (pad_out[0] == $past(port_latch_bit[0]) ||
             st.out_sel[0] != pin_routing_pkg::SRC_LATCH))
        else $error("output selector write not applied on schedule");

    AST_INDEPENDENT: assert property (@(posedge clk_sys) disable iff (rst)
        bus_accept && avs_write && hit_in |=> (st.out_sel == $past(st.out_sel)))
        else $error("input selector write disturbed output selectors");

    AST_WAIT_ONE: assert property (@(posedge clk_sys) disable iff (rst)
        bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest did not drop for exactly one cycle");

    // An idle bus must leave waitrequest high so a new request is never answered early.
    AST_WAIT_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
        !bus_req |=> avs_waitrequest)
        else $error("waitrequest low without a request");

    AST_ANALOG_BLOCKS: assert property (@(posedge clk_sys) disable iff (rst)
        pin_routing_pkg::sel_valid(st.in_sel[0]) &&
            analog_select_bit[pin_routing_pkg::sel_pin(st.in_sel[0])] |=>
            !periph_in[0])
        else $error("analog pin still fed input 0");

    AST_INPUT_FOLLOWS: assert property (@(posedge clk_sys) disable iff (rst)
        pin_routing_pkg::sel_valid(st.in_sel[19]) |=>
            (periph_in[19] ==
             $past(digital_level[pin_routing_pkg::sel_pin(st.in_sel[19])])))
        else $error("input 19 does not follow its selected pin");

    // A write accepted at address IN_SEL_BASE lands in input selector 0 at the accepting edge.
    AST_INPUT_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
        bus_accept && avs_write && avs_byteenable[0] &&
            (avs_address == pin_routing_pkg::IN_SEL_BASE) |=>
            (st.in_sel[0] == $past(avs_writedata[pin_routing_pkg::SEL_W-1:0])))
        else $error("input selector 0 write not applied");

    AST_OUT_WRITE_PIN: assert property (@(posedge clk_sys) disable iff (rst)
        bus_accept && avs_write && avs_byteenable[0] && hit_out && (out_offset == 7'h04) |=>
            (st.out_sel[4] == $past(avs_writedata[pin_routing_pkg::SEL_W-1:0])) &&
            (st.out_sel[5] == $past(st.out_sel[5])))
        else $error("pin 4 selector write missed or touched pin 5");

    AST_MASKED_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
        bus_accept && avs_write && !avs_byteenable[0] |=>
            (st.in_sel == $past(st.in_sel)) && (st.out_sel == $past(st.out_sel)))
        else $error("write with low byte disabled changed a selector");

    AST_OUT_INDEPENDENT: assert property (@(posedge clk_sys) disable iff (rst)
        bus_accept && avs_write && hit_out |=> (st.in_sel == $past(st.in_sel)))
        else $error("output selector write disturbed input selectors");

    // The level register must give the registered pin level, not a routed copy.
    AST_READ_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
        bus_req && st.waitreq && (avs_address == pin_routing_pkg::PIN_LEVEL) |=>
            (avs_readdata[pin_routing_pkg::NUM_PINS-1:0] == $past(port_level)))
        else $error("pin level read returned wrong data");

    AST_UNMAPPED_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        bus_req && st.waitreq && !hit_in && !hit_out &&
            (avs_address != pin_routing_pkg::PIN_LEVEL) |=> (avs_readdata == '0))
        else $error("unmapped read returned nonzero data");

    AST_LATCH_OE: assert property (@(posedge clk_sys) disable iff (rst)
        (st.out_sel[0] == pin_routing_pkg::SRC_LATCH) |=>
            (pad_oe_n[0] == $past(pin_direction_control[0])))
        else $error("latch source lost direction control on pin 0");

    // Reserved codes must not let a stray override bit take the driver.
    AST_RESERVED_DIR: assert property (@(posedge clk_sys) disable iff (rst)
        code_reserved(st.out_sel[4]) |=>
            (pad_oe_n[4] == $past(pin_direction_control[4])))
        else $error("reserved code changed pin 4 driver control");

    AST_LATCH_NO_OVERRIDE: assert property (@(posedge clk_sys) disable iff (rst)
        (st.out_sel[4] == pin_routing_pkg::SRC_LATCH) |=>
            (pad_oe_n[4] == $past(pin_direction_control[4])))
        else $error("latch source on pin 4 took a peripheral override");

endmodule

// ### testbench/pad_model.sv
`timescale 1ns/1ps
module pad_model (
    input  wire logic [pin_routing_pkg::NUM_PINS-1:0] pad_out,
    input  wire logic [pin_routing_pkg::NUM_PINS-1:0] pad_oe_n,
    input  wire logic [pin_routing_pkg::NUM_PINS-1:0] ext_level,
    output logic      [pin_routing_pkg::NUM_PINS-1:0] pad_in
);
    // A driven pad shows the device value, so routed inputs see loopback on shared lines.
    always_comb begin
        for (int i = 0; i < pin_routing_pkg::NUM_PINS; i++) begin
            pad_in[i] = (pad_oe_n[i] === 1'b0) ? pad_out[i] : ext_level[i];
        end
    end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest;
    logic [6:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    logic [23:0] pad_in, pad_out, pad_oe_n, ext_level, analog_select_bit;
    logic [23:0] pin_direction_control, port_latch_bit, port_level;
    logic [35:1] periph_out, periph_dir_override, periph_drive_n;
    logic [29:0] periph_in;
    logic        e;
    int          err_total, checked;
    localparam logic [6:0] IB = pin_routing_pkg::IN_SEL_BASE;
    localparam logic [6:0] OB = pin_routing_pkg::OUT_SEL_BASE;

    peripheral_pin_router #(.PKG_20_PIN(1'b1)) dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .analog_select_bit(analog_select_bit), .pin_direction_control(pin_direction_control),
        .port_latch_bit(port_latch_bit), .periph_out(periph_out),
        .periph_dir_override(periph_dir_override), .periph_drive_n(periph_drive_n),
        .periph_in(periph_in), .port_level(port_level));
    pad_model u_pads (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext_level),
        .pad_in(pad_in));

    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Request is held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] r);
        int n;
        @(posedge clk_sys);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("ERROR %0t bus answer missing", $time);
            end_of_test();
        end
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] a, input logic [5:0] d);
        bus(1'b1, a, {26'h0, d}, 4'hF, q);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(q, exp, what);
    endtask

    // Routing lags its causes by one edge; three edges cover the loopback path too.
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic test_defaults;
        rdc(IB + 7'd19, 32'h0000_000E, "clock1 default");
        rdc(IB + 7'd20, 32'h0000_000C, "data1 default");
        rdc(OB + 7'd5, 32'h0, "output selector cleared");
        chk(pad_oe_n, 24'hFFFFFF, "drivers off");
        $display("test_defaults done");
    endtask

    task automatic test_inputs;
        @(posedge clk_sys);
        ext_level <= 24'h200800;
        wr(IB, 6'h0B);
        wr(IB + 7'd1, 6'h0B);
        wr(IB + 7'd2, 6'h15);
        settle();
        chk(periph_in[2:0], 3'h7, "shared and far pins");
        @(posedge clk_sys);
        analog_select_bit <= 24'h000800;
        settle();
        chk(periph_in[2:0], 3'h4, "analog blocks input");
        chk(port_level, 24'h200800, "port level");
        rdc(pin_routing_pkg::PIN_LEVEL, 32'h0020_0800, "level register");
        $display("test_inputs done");
    endtask

    task automatic test_outputs;
        @(posedge clk_sys);
        for (int i = 1; i < 36; i++)
            periph_out[i] <= i[0];
        port_latch_bit <= 24'h000030;
        pin_direction_control <= 24'hFFFFEF;
        for (int c = 0; c < 36; c++) begin
            wr(OB + 7'd4, c[5:0]);
            settle();
            if (c == 0)
                e = 1'b1;
            else if ((c >= 8'h0F && c <= 8'h12) || c == 8'h14 || c == 8'h17)
                e = 1'b0;
            else
                e = c[0];
            chk(pad_out[4], e, "source code");
            chk(pad_out[5], 1'b1, "other pin own selector");
            chk(pad_oe_n[4], 1'b0, "direction drives");
        end
        wr(OB, 6'h0B);
        settle();
        chk(pad_out[0], 1'b1, "pin 0 slice source");
        rdc(IB, 32'h0000_000B, "input kept");
        $display("test_outputs done");
    endtask

    task automatic test_override;
        @(posedge clk_sys);
        pin_direction_control <= 24'hFFFFFF;
        periph_dir_override[27] <= 1'b1;
        periph_drive_n[27] <= 1'b0;
        ext_level <= 24'h0;
        wr(OB + 7'd4, 6'h1B);
        wr(IB + 7'd19, 6'h04);
        settle();
        chk(pad_oe_n[4], 1'b0, "peripheral drives");
        chk(periph_in[19], 1'b1, "clock loopback");
        @(posedge clk_sys);
        periph_dir_override[27] <= 1'b0;
        settle();
        chk(pad_oe_n[4], 1'b1, "direction back");
        $display("test_override done");
    endtask

    task automatic test_refused;
        bus(1'b1, IB, 32'h0000_003F, 4'h0, q);
        rdc(IB, 32'h0000_000B, "masked write ignored");
        wr(7'h7F, 6'h3F);
        rdc(7'h7F, 32'h0, "unmapped reads zero");
        $display("test_refused done");
    endtask

    task automatic test_rereset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(IB, 32'h0000_0002, "input default back");
        rdc(OB + 7'd4, 32'h0, "output cleared");
        $display("test_rereset done");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("ERROR %0t run too long", $time);
        end_of_test();
    end

    initial begin
        err_total = 0;
        checked = 0;
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        {ext_level, analog_select_bit, port_latch_bit} = '0;
        pin_direction_control = 24'hFFFFFF;
        {periph_out, periph_dir_override, periph_drive_n} = '0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        test_defaults();
        test_inputs();
        test_outputs();
        test_override();
        test_refused();
        test_rereset();
        end_of_test();
    end
endmodule
